// >>> core/fcs_pkg.sv
// Constants and types for the float convert and seed ALU
// Assumes one core clock, registers reached over AXI4-Lite
package fcs_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  MODE_OFS    = 8'h04;
	localparam logic [7:0]  XHI_OFS     = 8'h08;
	localparam logic [7:0]  XLO_OFS     = 8'h0C;
	localparam logic [7:0]  YHI_OFS     = 8'h10;
	localparam logic [7:0]  YLO_OFS     = 8'h14;
	localparam logic [7:0]  RHI_OFS     = 8'h18;
	localparam logic [7:0]  RLO_OFS     = 8'h1C;
	localparam logic [7:0]  FLAGS_OFS   = 8'h20;
	localparam int          CTRL_SCALE  = 4;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [39:0] OPND_RST    = 40'h00_0000_0000;
	localparam logic [1:0]  MODE_RST    = 2'h0;
	// ************************************************************
	// Number formats
	// ************************************************************
	localparam int          EXP_BIAS     = 127;
	localparam int          EXP_MAX      = 255;
	localparam int          FIX_OVF_EXP  = 157;
	localparam int          FIX_TOP      = 31;
	localparam int          RCP_MAX_EXP  = 125;
	localparam int          RCP_EXP_SUM  = 253;
	localparam int          RSQ_EXP_BASE = 126;
	localparam logic [39:0] ALL_ONES     = 40'hFF_FFFF_FFFF;
	localparam logic [39:0] NEG_ONE_FIX  = 40'hFF_FFFF_FF00;
	localparam logic [31:0] SAT_POS      = 32'h7FFF_FFFF;
	localparam logic [31:0] SAT_NEG      = 32'h8000_0000;
	localparam logic [7:0]  EXT_ZERO     = 8'h00;
	localparam logic [38:0] INF_MAG      = 39'h7F_8000_0000;
	localparam logic [38:0] LARGEST_NORMAL_VALUE_MAG = 39'h7F_7FFF_FFFF;
	// ************************************************************
	// Seed tables
	// ************************************************************
	localparam int          TBL_DEPTH    = 128;
	localparam int          RSQ_HALF     = 64;
	localparam int          RCP_NUM      = 131072;
	localparam int          RCP_DEN_BASE = 257;
	localparam int          RSQ_DEN_BASE = 129;
	localparam int          RCP_ONE      = 256;
	localparam int          RSQ_ONE      = 16;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		OP_FLOAT_TO_INT_ROUNDING   = 4'h0,
		OP_FLOAT_TO_INT_TRUNCATING = 4'h1,
		OP_INT_TO_FLOAT            = 4'h2,
		OP_RECIPROCAL_SEED         = 4'h3,
		OP_INV_SQRT_SEED           = 4'h4,
		OP_SIGN_TRANSFER           = 4'h5,
		OP_MIN                     = 4'h6,
		OP_MAX                     = 4'h7,
		OP_MAGNITUDE_LIMIT         = 4'h8
	} fcs_op_e;
	typedef struct packed {
		logic alu_invalid_flag;
		logic alu_sign_flag;
		logic alu_carry_flag;
		logic alu_overflow_flag;
		logic alu_negative_flag;
		logic alu_underflow_flag;
		logic alu_zero_flag;
	} fcs_flags_s;
	typedef struct packed {
		logic alu_saturate;
		logic round_truncate;
	} fcs_mode_s;
	function automatic int unsigned fcs_isqrt(input int unsigned v);
		int unsigned r;
		r = 0;
		for (int i = 0; i < 64; i++) begin
			if ((r + 1) * (r + 1) <= v) begin
				r = r + 1;
			end
		end
		return r;
	endfunction
endpackage

// >>> core/fcs_alu.sv
// Float convert, seed, sign, min, max and magnitude_limit ALU with AXI4-Lite registers
// Assumes one clock CLK, synchronous active-low reset, single AXI master
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fcs_alu
	import fcs_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              S_AXI_AWVALID,
	output wire logic              S_AXI_AWREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_WVALID,
	output wire logic              S_AXI_WREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	output wire logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	output wire logic [1:0]        S_AXI_BRESP,
	input  wire logic              S_AXI_ARVALID,
	output wire logic              S_AXI_ARREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	output wire logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	output wire logic [31:0]       S_AXI_RDATA,
	output wire logic [1:0]        S_AXI_RRESP
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic              aw_got_ff, w_got_ff, wr_go, wr_map;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0]       wdata_ff, rdata_ff, rd_data;
	logic [3:0]        wstrb_ff;
	logic [1:0]        bresp_ff, rresp_ff, rd_resp;
	logic [39:0]       x_ff, y_ff, res_ff, nxt_res, xm, ym;
	fcs_flags_s        flags_ff, nxt_flags;
	fcs_mode_s         core_mode_register;
	fcs_op_e           op_ff;
	logic              scale_en_ff, start_ff;
	logic              xs, x_nan, x_inf, x_zero, y_nan, lt;
	logic signed [33:0] scale, fx_e, fx_u, fl_e;
	logic [4:0]        fx_sh, fl_p;
	logic [63:0]       fx_m;
	logic              fx_inc, fx_big, fx_unf, fx_ovf, floor_mode;
	logic [32:0]       fx_mag;
	logic [31:0]       fx_val, fl_mag, fl_norm;
	logic signed [9:0] rs_e;
	logic [7:0]        rcp_tbl [TBL_DEPTH];
	logic [3:0]        rsq_tbl [TBL_DEPTH];

	assign S_AXI_AWREADY = awready_ff;
	assign S_AXI_WREADY  = wready_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;
	assign S_AXI_ARREADY = arready_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [39:0] ord_key(input logic [39:0] a);
		return a[39] ? {1'b0, ~a[38:0]} : {1'b1, a[38:0]};
	endfunction

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			awready_ff <= 1'b0;
			aw_got_ff  <= 1'b0;
			awaddr_ff  <= '0;
		end else if (S_AXI_AWVALID & awready_ff) begin
			awready_ff <= 1'b0;
			aw_got_ff  <= 1'b1;
			awaddr_ff  <= S_AXI_AWADDR;
		end else if (wr_go) begin
			aw_got_ff  <= 1'b0;
		end else if (!aw_got_ff && !bvalid_ff) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wready_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (S_AXI_WVALID & wready_ff) begin
			wready_ff <= 1'b0;
			w_got_ff  <= 1'b1;
			wdata_ff  <= S_AXI_WDATA;
			wstrb_ff  <= S_AXI_WSTRB;
		end else if (wr_go) begin
			w_got_ff  <= 1'b0;
		end else if (!w_got_ff && !bvalid_ff) begin
			wready_ff <= 1'b1;
		end
	end

	always_comb begin
		if (awaddr_ff == CTRL_OFS || awaddr_ff == MODE_OFS) begin
			wr_map = 1'b1;
		end else if (awaddr_ff == XHI_OFS || awaddr_ff == XLO_OFS) begin
			wr_map = 1'b1;
		end else if (awaddr_ff == YHI_OFS || awaddr_ff == YLO_OFS) begin
			wr_map = 1'b1;
		end else if (awaddr_ff == RHI_OFS || awaddr_ff == RLO_OFS) begin
			wr_map = 1'b1;
		end else if (awaddr_ff == FLAGS_OFS) begin
			wr_map = 1'b1;
		end else begin
			wr_map = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Operand, mode and control registers
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			x_ff <= OPND_RST;
			y_ff <= OPND_RST;
		end else if (wr_go) begin
			if (awaddr_ff == XHI_OFS) begin
				x_ff[39:8] <= merge(x_ff[39:8], wdata_ff, wstrb_ff);
			end else if (awaddr_ff == XLO_OFS && wstrb_ff[0]) begin
				x_ff[7:0] <= wdata_ff[7:0];
			end else if (awaddr_ff == YHI_OFS) begin
				y_ff[39:8] <= merge(y_ff[39:8], wdata_ff, wstrb_ff);
			end else if (awaddr_ff == YLO_OFS && wstrb_ff[0]) begin
				y_ff[7:0] <= wdata_ff[7:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			core_mode_register <= MODE_RST;
		end else if (wr_go && awaddr_ff == MODE_OFS && wstrb_ff[0]) begin
			core_mode_register <= wdata_ff[1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			op_ff       <= OP_FLOAT_TO_INT_ROUNDING;
			scale_en_ff <= 1'b0;
			start_ff    <= 1'b0;
		end else begin
			start_ff <= wr_go && awaddr_ff == CTRL_OFS && wstrb_ff[0];
			if (wr_go && awaddr_ff == CTRL_OFS && wstrb_ff[0]) begin
				op_ff       <= fcs_op_e'(wdata_ff[3:0]);
				scale_en_ff <= wdata_ff[CTRL_SCALE];
			end
		end
	end

	// ************************************************************
	// Operand classes
	// ************************************************************
	assign xs     = x_ff[39];
	assign x_zero = ~|x_ff[38:31];
	assign x_nan  = (&x_ff[38:31]) & (|x_ff[30:0]);
	assign x_inf  = (&x_ff[38:31]) & ~(|x_ff[30:0]);
	assign y_nan  = (&y_ff[38:31]) & (|y_ff[30:0]);
	assign xm     = x_zero ? {xs, 39'h0} : x_ff;
	assign ym     = (~|y_ff[38:31]) ? {y_ff[39], 39'h0} : y_ff;
	assign scale  = scale_en_ff ? {{2{y_ff[39]}}, y_ff[39:8]} : '0;

	// ************************************************************
	// Float to integer
	// ************************************************************
	// exponent plus scale
	assign fx_e   = $signed({26'h0, x_ff[38:31]}) + scale;
	assign fx_u   = fx_e - 34'(EXP_BIAS);
	assign fx_big = fx_e > 34'(FIX_OVF_EXP);
	assign fx_unf = ~x_zero & ~x_nan & ~x_inf & fx_u[33];
	assign fx_sh  = 5'(34'(FIX_TOP) - fx_u);
	assign fx_m   = {1'b1, x_ff[30:0], 32'h0} >> fx_sh;
	assign floor_mode = (op_ff == OP_FLOAT_TO_INT_ROUNDING) & core_mode_register.round_truncate;

	always_comb begin
		if (op_ff == OP_FLOAT_TO_INT_TRUNCATING) begin
			fx_inc = 1'b0;
		end else if (core_mode_register.round_truncate) begin
			fx_inc = xs & (|fx_m[31:0]);
		end else begin
			fx_inc = fx_m[31] & ((|fx_m[30:0]) | fx_m[32]);
		end
	end

	assign fx_mag = {1'b0, fx_m[63:32]} + {32'h0, fx_inc};
	assign fx_val = xs ? 32'(33'h0 - fx_mag) : fx_mag[31:0];
	assign fx_ovf = x_inf | (~x_zero & ~x_nan & (fx_big | (~fx_unf & ~xs & fx_mag[31])));

	// ************************************************************
	// Integer to float
	// ************************************************************
	assign fl_mag = x_ff[39] ? 32'(32'h0 - x_ff[39:8]) : x_ff[39:8];

	always_comb begin
		fl_p = '0;
		for (int i = 0; i < 32; i++) begin
			if (fl_mag[i]) begin
				fl_p = 5'(i);
			end
		end
	end

	assign fl_norm = fl_mag << (5'd31 - fl_p);
	assign fl_e    = $signed({29'h0, fl_p}) + scale + 34'(EXP_BIAS);

	// ************************************************************
	// Seed tables
	// ************************************************************
	assign rs_e = $signed({2'h0, x_ff[38:31]}) - 10'(EXP_BIAS);

	for (genvar g = 0; g < TBL_DEPTH; g++) begin : g_tbl
		assign rcp_tbl[g] = 8'(RCP_NUM / (RCP_DEN_BASE + 2 * g) - RCP_ONE);
		assign rsq_tbl[g] = 4'(fcs_isqrt(RCP_NUM / ((RSQ_DEN_BASE + 2 * (g % RSQ_HALF))
			<< (1 - g / RSQ_HALF))) - RSQ_ONE);
	end

	// ************************************************************
	// Operation select
	// ************************************************************
	assign lt = ord_key(xm) < ord_key(ym);

	always_comb begin
		nxt_res   = '0;
		nxt_flags = '0;
		case (op_ff)
			OP_FLOAT_TO_INT_ROUNDING, OP_FLOAT_TO_INT_TRUNCATING: begin
				if (x_nan) begin
					nxt_res = ALL_ONES;
				end else if (fx_ovf) begin
					if (core_mode_register.alu_saturate) begin
						nxt_res = {xs ? SAT_NEG : SAT_POS, EXT_ZERO};
					end else begin
						nxt_res = ALL_ONES;
					end
				end else if (x_zero) begin
					nxt_res = '0;
				end else if (fx_unf) begin
					nxt_res = (xs & floor_mode) ? NEG_ONE_FIX : '0;
				end else begin
					nxt_res = {fx_val, EXT_ZERO};
				end
				nxt_flags.alu_zero_flag      = ~|nxt_res[39:8];
				nxt_flags.alu_negative_flag  = nxt_res[39];
				nxt_flags.alu_underflow_flag = fx_unf;
				nxt_flags.alu_overflow_flag  = fx_ovf;
				nxt_flags.alu_invalid_flag   = x_nan | (~core_mode_register.alu_saturate & fx_ovf);
			end
			OP_INT_TO_FLOAT: begin
				if (fl_mag == 32'h0) begin
					nxt_res = '0;
				end else if (fl_e >= 34'(EXP_MAX)) begin
					nxt_res = {x_ff[39], core_mode_register.round_truncate ? LARGEST_NORMAL_VALUE_MAG : INF_MAG};
					nxt_flags.alu_overflow_flag = 1'b1;
				end else if (fl_e <= 34'sd0) begin
					nxt_res = {x_ff[39], 39'h0};
					nxt_flags.alu_underflow_flag = 1'b1;
				end else begin
					nxt_res = {x_ff[39], fl_e[7:0], fl_norm[30:0]};
				end
				nxt_flags.alu_zero_flag     = ~|nxt_res[38:31];
				nxt_flags.alu_negative_flag = nxt_res[39];
			end
			OP_RECIPROCAL_SEED: begin
				nxt_flags.alu_negative_flag = xs;
				if (x_nan) begin
					nxt_res = ALL_ONES;
					nxt_flags.alu_invalid_flag = 1'b1;
				end else if (x_zero) begin
					nxt_res = {xs, INF_MAG};
					nxt_flags.alu_overflow_flag = 1'b1;
				end else if (x_ff[38:31] > 8'(EXP_BIAS + RCP_MAX_EXP)) begin
					nxt_res = {xs, 39'h0};
					nxt_flags.alu_zero_flag = 1'b1;
				end else begin
					nxt_res = {xs, 8'(9'(RCP_EXP_SUM) - {1'b0, x_ff[38:31]}),
						rcp_tbl[x_ff[30:24]], 23'h0};
				end
			end
			OP_INV_SQRT_SEED: begin
				nxt_flags.alu_negative_flag = xs & x_zero;
				if (x_nan || (xs && !x_zero)) begin
					nxt_res = ALL_ONES;
					nxt_flags.alu_invalid_flag = 1'b1;
				end else if (x_zero) begin
					nxt_res = {xs, INF_MAG};
					nxt_flags.alu_overflow_flag = 1'b1;
				end else if (x_inf) begin
					nxt_res = '0;
					nxt_flags.alu_zero_flag = 1'b1;
				end else begin
					nxt_res = {xs, 8'(10'(RSQ_EXP_BASE) - (rs_e >>> 1)),
						rsq_tbl[{x_ff[31], x_ff[30:25]}], 27'h0};
				end
			end
			OP_SIGN_TRANSFER, OP_MIN, OP_MAX, OP_MAGNITUDE_LIMIT: begin
				if (x_nan || y_nan) begin
					nxt_res = ALL_ONES;
					nxt_flags.alu_invalid_flag = 1'b1;
				end else if (op_ff == OP_SIGN_TRANSFER) begin
					nxt_res = {y_ff[39], xm[38:0]};
				end else if (op_ff == OP_MIN) begin
					nxt_res = lt ? xm : ym;
				end else if (op_ff == OP_MAX) begin
					nxt_res = lt ? ym : xm;
				end else begin
					nxt_res = (xm[38:0] < ym[38:0]) ? xm : {xm[39], ym[38:0]};
				end
				nxt_flags.alu_zero_flag     = ~|nxt_res[38:31];
				nxt_flags.alu_negative_flag = nxt_res[39] & ~nxt_flags.alu_invalid_flag;
			end
			default: begin
				nxt_res   = '0;
				nxt_flags = '0;
			end
		endcase
	end

	// ************************************************************
	// Result and flags
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			res_ff   <= OPND_RST;
			flags_ff <= '0;
		end else if (start_ff) begin
			res_ff   <= nxt_res;
			flags_ff <= nxt_flags;
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	always_comb begin
		rd_data = '0;
		rd_resp = RESP_OKAY;
		if (S_AXI_ARADDR == CTRL_OFS) begin
			rd_data = {27'h0, scale_en_ff, op_ff};
		end else if (S_AXI_ARADDR == MODE_OFS) begin
			rd_data = {30'h0, core_mode_register};
		end else if (S_AXI_ARADDR == XHI_OFS) begin
			rd_data = x_ff[39:8];
		end else if (S_AXI_ARADDR == XLO_OFS) begin
			rd_data = {24'h0, x_ff[7:0]};
		end else if (S_AXI_ARADDR == YHI_OFS) begin
			rd_data = y_ff[39:8];
		end else if (S_AXI_ARADDR == YLO_OFS) begin
			rd_data = {24'h0, y_ff[7:0]};
		end else if (S_AXI_ARADDR == RHI_OFS) begin
			rd_data = res_ff[39:8];
		end else if (S_AXI_ARADDR == RLO_OFS) begin
			rd_data = {24'h0, res_ff[7:0]};
		end else if (S_AXI_ARADDR == FLAGS_OFS) begin
			rd_data = {25'h0, flags_ff};
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (S_AXI_ARVALID & arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_data;
			rresp_ff   <= rd_resp;
		end else if (rvalid_ff) begin
			if (S_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end else begin
			arready_ff <= 1'b1;
		end
	end
endmodule

// >>> test/fcs_alu_checker.sv
// Handshake checker for the register port of fcs_alu
// Assumes one clock CLK and synchronous active-low RST_N
`timescale 1ns/1ps
module fcs_alu_checker
	import fcs_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP
);
	// ************************************************************
	// Answer timing
	// ************************************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	wr_answer_a:
	assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##2 S_AXI_BVALID) else $error("write answer not on time");
	rd_answer_a:
	assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer not on time");
	b_release_a:
	assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID ##[1:2]
		(S_AXI_AWREADY && S_AXI_WREADY)) else $error("write side not freed");
	r_release_a:
	assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID ##[0:1] S_AXI_ARREADY)
		else $error("read side not freed");
	w_refuse_a:
	assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken during answer");
	r_refuse_a:
	assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken during answer");
	commit_gap_a:
	assert property ($rose(S_AXI_BVALID) |-> !$past(S_AXI_AWREADY) && !$past(S_AXI_WREADY))
		else $error("answer without commit cycle");
	err_data_a:
	assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0000_0000)
		else $error("error read carries data");
endmodule
bind fcs_alu fcs_alu_checker u_chk (.*);

// >>> test/fcs_axi_master.sv
// Register bus master standing in for the sequencer side
// Assumes tb calls wr and rd one at a time after reset
`timescale 1ns/1ps
module fcs_axi_master
	import fcs_pkg::*;
(
	input  wire logic              CLK,
	output logic                   S_AXI_AWVALID,
	input  wire logic              S_AXI_AWREADY,
	output logic [ADDR_W-1:0]      S_AXI_AWADDR,
	output logic                   S_AXI_WVALID,
	input  wire logic              S_AXI_WREADY,
	output logic [31:0]            S_AXI_WDATA,
	output logic [3:0]             S_AXI_WSTRB,
	input  wire logic              S_AXI_BVALID,
	output logic                   S_AXI_BREADY,
	input  wire logic [1:0]        S_AXI_BRESP,
	output logic                   S_AXI_ARVALID,
	input  wire logic              S_AXI_ARREADY,
	output logic [ADDR_W-1:0]      S_AXI_ARADDR,
	input  wire logic              S_AXI_RVALID,
	output logic                   S_AXI_RREADY,
	input  wire logic [31:0]       S_AXI_RDATA,
	input  wire logic [1:0]        S_AXI_RRESP
);
	logic hang = 1'b0;
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = 20'h0_0000;
		S_AXI_WDATA = 32'h0000_0000;
	end
	// Released lines show inverted data
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= 4'hF;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				S_AXI_AWVALID <= 1'b0;
				S_AXI_AWADDR <= ~a;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				S_AXI_WVALID <= 1'b0;
				S_AXI_WDATA <= ~d;
			end
		end while (!S_AXI_BVALID && n < 64);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
		if (!S_AXI_BVALID) hang = 1'b1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARVALID <= 1'b0;
				S_AXI_ARADDR <= ~a;
			end
		end while (!S_AXI_RVALID && n < 64);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
		if (!S_AXI_RVALID) hang = 1'b1;
	endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for fcs_alu through its register port
// Assumes fcs_axi_master as bus master and the bound checker
`timescale 1ns/1ps
`define CHK(nm, g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) begin \
			miscompares++; \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
		end \
	end
module tb
	import fcs_pkg::*;
;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
	wire logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	wire logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	wire logic [31:0]       S_AXI_WDATA, S_AXI_RDATA;
	wire logic [3:0]        S_AXI_WSTRB;
	wire logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
	int miscompares = 0;
	int check_count = 0;
	localparam logic [39:0] F1 = 40'h3F_8000_0000;
	localparam logic [39:0] FM3 = 40'hC0_4000_0000;
	localparam logic [39:0] FNZ = 40'h80_0000_0000;
	localparam logic [39:0] FPI = 40'h7F_8000_0000;
	localparam logic [39:0] FNAN = 40'h7F_8000_0001;
	localparam logic [39:0] Z = 40'h0;
	always #12.5 CLK = ~CLK;
	fcs_alu DUT (.*);
	fcs_axi_master MST (.*);
	always @(posedge MST.hang) begin
		miscompares++;
		end_of_test();
	end
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// k: [6:5] mode, [4] scale enable, [3:0] op
	task automatic run(input logic [7:0] k, input logic [39:0] x, y, r, input logic [6:0] f);
		logic [31:0] hi, lo, fl;
		logic [1:0]  rs;
		MST.wr(MODE_OFS, {30'h0000_0000, k[6:5]}, rs);
		MST.wr(XHI_OFS, x[39:8], rs);
		MST.wr(XLO_OFS, {24'h00_0000, x[7:0]}, rs);
		MST.wr(YHI_OFS, y[39:8], rs);
		MST.wr(YLO_OFS, {24'h00_0000, y[7:0]}, rs);
		MST.wr(CTRL_OFS, {27'h000_0000, k[4:0]}, rs);
		`CHK("ctrl resp", rs, RESP_OKAY)
		MST.rd(RHI_OFS, hi, rs);
		MST.rd(RLO_OFS, lo, rs);
		MST.rd(FLAGS_OFS, fl, rs);
		`CHK("result", {hi, lo[7:0]}, r)
		`CHK("flags", fl[6:0], f)
	endtask
	task automatic regs_scn();
		logic [31:0] d;
		logic [1:0]  rs;
		MST.rd(8'h40, d, rs);
		`CHK("unmapped rd", {rs, d}, {RESP_SLVERR, 32'h0000_0000})
		MST.wr(8'h44, 32'hFFFF_FFFF, rs);
		`CHK("unmapped wr", rs, RESP_SLVERR)
		MST.wr(FLAGS_OFS, 32'h0000_007F, rs);
		MST.rd(FLAGS_OFS, d, rs);
		`CHK("ro flags", {rs, d}, {RESP_OKAY, 32'h0000_0000})
		MST.wr(XHI_OFS, 32'h1234_5678, rs);
		MST.rd(XHI_OFS, d, rs);
		`CHK("operand rd", {rs, d}, {RESP_OKAY, 32'h1234_5678})
	endtask
	task automatic fix_scn();
		run(8'h00, 40'hC0_2000_0000, Z, 40'hFF_FFFF_FE00, 7'h04);
		run(8'h20, 40'hC0_2000_0000, Z, 40'hFF_FFFF_FD00, 7'h04);
		run(8'h21, 40'hC0_2000_0000, Z, 40'hFF_FFFF_FE00, 7'h04);
		run(8'h00, 40'h40_6000_0000, Z, 40'h00_0000_0400, 7'h00);
		run(8'h40, FPI, Z, 40'h7F_FFFF_FF00, 7'h08);
		run(8'h40, 40'hFF_8000_0000, Z, 40'h80_0000_0000, 7'h0C);
		run(8'h00, FPI, Z, ALL_ONES, 7'h4C);
		run(8'h40, FNAN, Z, ALL_ONES, 7'h44);
		run(8'h10, F1, 40'h00_0000_0300, 40'h00_0000_0800, 7'h00);
		run(8'h00, F1, 40'h00_0000_0300, 40'h00_0000_0100, 7'h00);
		run(8'h10, F1, 40'h00_0000_1E00, 40'h40_0000_0000, 7'h00);
		run(8'h50, F1, 40'h00_0000_1F00, 40'h7F_FFFF_FF00, 7'h08);
		run(8'h20, 40'hBF_0000_0000, Z, NEG_ONE_FIX, 7'h06);
		run(8'h00, 40'hBF_0000_0000, Z, Z, 7'h03);
	endtask
	task automatic float_scn();
		run(8'h02, 40'h00_0000_0300, Z, 40'h40_4000_0000, 7'h00);
		run(8'h12, 40'h00_0000_0300, 40'h00_0000_0200, 40'h41_4000_0000, 7'h00);
		run(8'h02, 40'hFF_FFFF_FF00, Z, 40'hBF_8000_0000, 7'h04);
		run(8'h12, 40'h00_0000_0100, 40'h00_0000_C800, {1'b0, INF_MAG}, 7'h08);
		run(8'h32, 40'h00_0000_0100, 40'h00_0000_C800, {1'b0, LARGEST_NORMAL_VALUE_MAG}, 7'h08);
		run(8'h12, 40'h00_0000_0100, 40'hFF_FFFF_3800, Z, 7'h03);
	endtask
	task automatic seed_scn();
		run(8'h03, F1, Z, 40'h3F_7F00_0000, 7'h00);
		run(8'h03, 40'hC0_0000_0000, Z, 40'hBE_FF00_0000, 7'h04);
		run(8'h03, 40'h7E_0000_0000, Z, 40'h00_FF00_0000, 7'h00);
		run(8'h03, 40'h7E_8000_0000, Z, Z, 7'h01);
		run(8'h03, FNZ, Z, {1'b1, INF_MAG}, 7'h0C);
		run(8'h03, FNAN, Z, ALL_ONES, 7'h40);
		run(8'h04, 40'h40_8000_0000, Z, 40'h3E_F800_0000, 7'h00);
		run(8'h04, 40'h3F_0000_0000, Z, 40'h3F_B000_0000, 7'h00);
		run(8'h04, FNZ, Z, {1'b1, INF_MAG}, 7'h0C);
		run(8'h04, FPI, Z, Z, 7'h01);
		run(8'h04, 40'hC0_0000_0000, Z, ALL_ONES, 7'h40);
	endtask
	task automatic misc_scn();
		run(8'h05, F1, FM3, 40'hBF_8000_0000, 7'h04);
		run(8'h05, 40'h00_0000_0005, FM3, FNZ, 7'h05);
		run(8'h06, Z, FNZ, FNZ, 7'h05);
		run(8'h07, Z, FNZ, Z, 7'h01);
		run(8'h06, F1, FM3, FM3, 7'h04);
		run(8'h08, 40'hC0_A000_0000, 40'h40_0000_0000, 40'hC0_0000_0000, 7'h04);
		run(8'h08, F1, 40'h40_0000_0000, F1, 7'h00);
		run(8'h09, F1, F1, Z, 7'h00);
	endtask
	initial begin
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge CLK);
		regs_scn();
		fix_scn();
		float_scn();
		seed_scn();
		misc_scn();
		end_of_test();
	end
endmodule
